//--- pwt_timer.sv
// Purpose: periodic wakeup timer with prescaler, modulo compare and flag
// Assumes: source ticks are one-cycle enables synchronous to clock_i
// Notes:   registers reached over a plain strobe port, read data one cycle later
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pwt_consts.svh"

module pwt_timer
(
	input  wire logic             clock_i,
	input  wire logic             resetn_i,
	input  wire pwt_pkg::pwt_addr_t addr_i,
	input  wire pwt_pkg::pwt_data_t wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic [7:0]            rdata_o,
	input  wire logic             osc_tick_i,
	input  wire logic             fast_bus_clock_i,
	input  wire logic             stop_mode_i,
	input  wire logic             vector_fetch_i,
	output logic                  periodic_wakeup_unit_irq_o,
	output logic                  wakeup_req_o,
	output logic                  irq_o
);
	import pwt_pkg::*;

	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic                 run_ff;
	logic                 src_ff;
	logic                 flag_ff;
	logic                 ie_ff;
	logic                 stoprun_ff;
	logic [3:0]           rate_ff;
	logic [7:0]           limit_ff;
	logic [7:0]           count_ff;
	logic [`PWT_DIV_W-1:0] div_ff;
	logic [1:0]           stat_ff;
	logic [1:0]           mask_ff;
	logic                 prev_fetch_ff;

	logic                 active;
	logic                 src_tick;
	logic                 counter_tick;
	logic                 match;
	logic                 wr_ctrl;
	logic                 ack;
	logic                 fetch_clr;
	logic [`PWT_DIV_W:0]  div_mask;

	assign wr_ctrl = wr_i && (addr_i == `PWT_ADDR_CTRL);
	assign ack     = wr_ctrl && wdata_i[`PWT_BIT_ACK];
	assign fetch_clr = vector_fetch_i && !prev_fetch_ff;

	// ----------------------------------------
	// run gating and tick selection
	// ----------------------------------------
	assign active   = run_ff && (!stop_mode_i || stoprun_ff);
	assign src_tick = src_ff ? fast_bus_clock_i : osc_tick_i;
	assign div_mask = (`PWT_DIV_W+1)'((17'h1 << rate_ff) - 17'h1);

	// divide by 2**rate: tick when low rate bits of divider are all ones
	assign counter_tick = active && src_tick &&
		((div_ff & div_mask[`PWT_DIV_W-1:0]) == div_mask[`PWT_DIV_W-1:0]);
	assign match = counter_tick && (count_ff == limit_ff);

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			prev_fetch_ff <= 1'b0;
		else
			prev_fetch_ff <= vector_fetch_i;
	end

	// ----------------------------------------
	// control/status register
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			run_ff     <= 1'b0;
			src_ff     <= 1'b0;
			ie_ff      <= 1'b0;
			stoprun_ff <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			run_ff     <= wdata_i[`PWT_BIT_RUN];
			ie_ff      <= wdata_i[`PWT_BIT_IE];
			stoprun_ff <= wdata_i[`PWT_BIT_STOPRUN];
			if (!run_ff)
				src_ff <= wdata_i[`PWT_BIT_SRC];
		end
	end

	// ----------------------------------------
	// rate and limit registers
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rate_ff  <= `PWT_RST_RATE;
			limit_ff <= `PWT_RST_LIMIT;
		end
		else if (wr_i && !run_ff)
		begin
			if (addr_i == `PWT_ADDR_RATE)
				rate_ff <= wdata_i[3:0];
			if (addr_i == `PWT_ADDR_LIMIT)
				limit_ff <= wdata_i;
		end
	end

	// ----------------------------------------
	// prescaler and counter
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			div_ff <= '0;
		else if (!active)
			div_ff <= '0;
		else if (src_tick)
			div_ff <= div_ff + 1'b1;
	end

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			count_ff <= 8'h00;
		else if (!active)
			count_ff <= 8'h00;
		else if (match)
			count_ff <= 8'h00;
		else if (counter_tick)
			count_ff <= count_ff + 8'h01;
	end

	// ----------------------------------------
	// period flag
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			flag_ff <= 1'b0;
		else if (match)
			flag_ff <= 1'b1;
		else if (ack || fetch_clr)
			flag_ff <= 1'b0;
	end

	// ----------------------------------------
	// interrupt request and wakeup outputs
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			periodic_wakeup_unit_irq_o <= 1'b0;
			wakeup_req_o               <= 1'b0;
		end
		else
		begin
			periodic_wakeup_unit_irq_o <= (flag_ff || match) && ie_ff &&
				!((ack || fetch_clr) && !match);
			// wakeup drops with the request when the flag is cleared
			wakeup_req_o <= stop_mode_i && stoprun_ff && run_ff && ie_ff &&
				(flag_ff || match) && !((ack || fetch_clr) && !match);
		end
	end

	// ----------------------------------------
	// sticky status: bit0 match, bit1 write refused
	// ----------------------------------------
	logic locked_wr;
	assign locked_wr = wr_i && run_ff && ((addr_i == `PWT_ADDR_RATE) ||
		(addr_i == `PWT_ADDR_LIMIT));

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			stat_ff <= 2'h0;
		else
			stat_ff <= (stat_ff & ~((wr_i && addr_i == `PWT_ADDR_IRQ_STAT) ?
				wdata_i[1:0] : 2'h0)) | {locked_wr, match};
	end

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			mask_ff <= `PWT_RST_MASK;
		else if (wr_i && addr_i == `PWT_ADDR_IRQ_MASK)
			mask_ff <= wdata_i[1:0];
	end

	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(stat_ff & mask_ff);
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_o <= 8'h00;
		else if (rd_i)
		begin
			unique case (addr_i)
				`PWT_ADDR_CTRL:
					rdata_o <= {2'h0, stoprun_ff, ie_ff, 1'b0, flag_ff,
						src_ff, run_ff};
				`PWT_ADDR_RATE:     rdata_o <= {4'h0, rate_ff};
				`PWT_ADDR_LIMIT:    rdata_o <= limit_ff;
				`PWT_ADDR_IRQ_STAT: rdata_o <= {6'h00, stat_ff};
				`PWT_ADDR_IRQ_MASK: rdata_o <= {6'h00, mask_ff};
				default:            rdata_o <= 8'h00;
			endcase
		end
		else
			rdata_o <= 8'h00;
	end
endmodule

//--- pwt_consts.svh
// Purpose: constants for the periodic wakeup timer
// Assumes: 20 MHz block clock, plain register port
// Notes:   offsets, field positions, reset values
`ifndef PWT_CONSTS_SVH
`define PWT_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PWT_ADDR_CTRL     4'h0
`define PWT_ADDR_RATE     4'h1
`define PWT_ADDR_LIMIT    4'h2
`define PWT_ADDR_IRQ_STAT 4'h3
`define PWT_ADDR_IRQ_MASK 4'h4

// ----------------------------------------
// control/status bit positions
// ----------------------------------------
`define PWT_BIT_RUN       0
`define PWT_BIT_SRC       1
`define PWT_BIT_FLAG      2
`define PWT_BIT_ACK       3
`define PWT_BIT_IE        4
`define PWT_BIT_STOPRUN   5

// ----------------------------------------
// reset values
// ----------------------------------------
`define PWT_RST_CTRL      8'h00
`define PWT_RST_RATE      4'h0
`define PWT_RST_LIMIT     8'h00
`define PWT_RST_MASK      2'h0

// ----------------------------------------
// widths and counts
// ----------------------------------------
`define PWT_DIV_W         15
`define PWT_OSC_KHZ       32

`endif

//--- pwt_pkg.sv
// Purpose: types for the periodic wakeup timer
// Assumes: nothing
// Notes:   constants live in pwt_consts.svh
package pwt_pkg;
	typedef logic [3:0] pwt_addr_t;
	typedef logic [7:0] pwt_data_t;
endpackage

//--- pwt_timer_sva.sv
// Purpose: port assertions for pwt_timer
// Assumes: one clock domain
// Notes:   bound at the foot
`timescale 1ns/1ps
`include "pwt_consts.svh"
module pwt_timer_sva
(
	input wire logic       clock_i,
	input wire logic       resetn_i,
	input wire logic [3:0] addr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       stop_mode_i,
	input wire logic       periodic_wakeup_unit_irq_o,
	input wire logic       wakeup_req_o,
	input wire logic       irq_o
);
	// ------
	// checks
	// ------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	idle_read_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	ack_reads_zero_a: assert property ($past(rd_i) && $past(addr_i) == `PWT_ADDR_CTRL
		|-> rdata_o[3] == 1'b0 && rdata_o[7:6] == 2'h0) else $error("ack bit read back");
	rate_width_a: assert property ($past(rd_i) && $past(addr_i) == `PWT_ADDR_RATE
		|-> rdata_o[7:4] == 4'h0) else $error("rate upper bits set");
	unmapped_zero_a: assert property ($past(rd_i) && $past(addr_i) > 4'h4
		|-> rdata_o == 8'h00) else $error("unmapped read not zero");
	status_width_a: assert property ($past(rd_i) && $past(addr_i) == `PWT_ADDR_IRQ_STAT
		|-> rdata_o[7:2] == 6'h00) else $error("status upper bits set");
	quiet_start_a: assert property ($rose(resetn_i)
		|-> !irq_o && !wakeup_req_o && !periodic_wakeup_unit_irq_o) else $error("output after reset");
	wake_in_stop_a: assert property (wakeup_req_o |-> $past(stop_mode_i))
		else $error("wakeup outside stop");
	wake_needs_irq_a: assert property (wakeup_req_o |-> periodic_wakeup_unit_irq_o)
		else $error("wakeup without request");
endmodule
bind pwt_timer pwt_timer_sva chk (.*);

//--- periodic_wakeup_timer_tb.sv
// Purpose: scenario bench for pwt_timer
// Assumes: osc tick every 2nd cycle, fast tick every cycle
// Notes:   one task per scenario
`timescale 1ns/1ps
`include "pwt_consts.svh"
module periodic_wakeup_timer_tb;
	import pwt_pkg::*;
	logic      clock_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic      osc = 1'b0, stop = 1'b0, vf = 1'b0, periodic_wakeup_unit, wake, irq;
	logic [7:0] rdata, d;
	pwt_addr_t addr = 4'h0;
	pwt_data_t wdata = 8'h00;
	int        n_errors = 0, n_tests = 0, cyc = 0, t0;
	always #25 clock_i = ~clock_i;
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		osc <= ~osc;
		if (cyc == 90000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	pwt_timer DUT (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .osc_tick_i(osc), .fast_bus_clock_i(1'b1),
		.stop_mode_i(stop), .vector_fetch_i(vf), .periodic_wakeup_unit_irq_o(periodic_wakeup_unit),
		.wakeup_req_o(wake), .irq_o(irq));
	// ----------
	// bus tasks
	// ----------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input pwt_addr_t a, input pwt_data_t v);
		@(posedge clock_i);
		addr <= a;
		wdata <= v;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input pwt_addr_t a);
		@(posedge clock_i);
		addr <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_rise();
		repeat (2) @(posedge clock_i);
		for (int k = 0; k < 40000 && periodic_wakeup_unit !== 1'b1; k++)
			@(posedge clock_i);
		#1 check({7'h0, periodic_wakeup_unit}, 8'h01);
	endtask
	// ---------
	// scenarios
	// ---------
	task automatic t_regs();
		for (int a = 0; a < 8; a++)
		begin
			rd(a[3:0]);
			check(d, 8'h00);
		end
		$display("test regs done");
	endtask
	task automatic t_period(input logic s, input logic [3:0] r, input pwt_data_t l, input int p);
		wr(`PWT_ADDR_CTRL, 8'h00);
		wr(`PWT_ADDR_RATE, {4'h0, r});
		wr(`PWT_ADDR_LIMIT, l);
		wr(`PWT_ADDR_CTRL, {6'h06, s, 1'b1});
		wait_rise();
		t0 = cyc;
		wr(`PWT_ADDR_CTRL, {6'h06, s, 1'b1});
		wait_rise();
		check({7'h0, cyc - t0 == p}, 8'h01);
		$display("test period done");
	endtask
	task automatic t_lock();
		wr(`PWT_ADDR_RATE, 8'h05);
		wr(`PWT_ADDR_LIMIT, 8'h09);
		wr(`PWT_ADDR_CTRL, 8'h13);
		rd(`PWT_ADDR_RATE);
		check(d, 8'h02);
		rd(`PWT_ADDR_LIMIT);
		check(d, 8'h03);
		rd(`PWT_ADDR_CTRL);
		check(d & 8'h1b, 8'h11);
		rd(`PWT_ADDR_IRQ_STAT);
		check(d & 8'h02, 8'h02);
		wr(`PWT_ADDR_IRQ_STAT, 8'h02);
		rd(`PWT_ADDR_IRQ_STAT);
		check(d & 8'h02, 8'h00);
		wr(`PWT_ADDR_IRQ_MASK, 8'h01);
		repeat (40) @(posedge clock_i);
		#1 check({7'h0, irq}, 8'h01);
		wr(`PWT_ADDR_IRQ_MASK, 8'h00);
		repeat (3) @(posedge clock_i);
		#1 check({7'h0, irq}, 8'h00);
		$display("test lock done");
	endtask
	task automatic t_stop();
		wr(`PWT_ADDR_CTRL, 8'h39);
		stop <= 1'b1;
		repeat (40) @(posedge clock_i);
		#1 check({7'h0, wake}, 8'h01);
		wr(`PWT_ADDR_CTRL, 8'h19);
		repeat (80) @(posedge clock_i);
		#1 check({6'h0, wake, periodic_wakeup_unit}, 8'h00);
		stop <= 1'b0;
		wr(`PWT_ADDR_CTRL, 8'h01);
		repeat (40) @(posedge clock_i);
		#1 check({7'h0, periodic_wakeup_unit}, 8'h00);
		rd(`PWT_ADDR_CTRL);
		check(d & 8'h04, 8'h04);
		$display("test stop done");
	endtask
	task automatic t_fetch();
		@(posedge clock_i);
		vf <= 1'b1;
		@(posedge clock_i);
		vf <= 1'b0;
		repeat (3) @(posedge clock_i);
		#1 check({7'h0, periodic_wakeup_unit}, 8'h00);
		$display("test fetch done");
	endtask
	task automatic tally_and_finish();
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clock_i);
		resetn_i <= 1'b1;
		t_regs();
		t_period(1'b1, 4'h0, 8'h07, 8);
		t_period(1'b0, 4'h2, 8'h03, 32);
		t_lock();
		t_stop();
		t_period(1'b1, 4'hf, 8'h00, 32768);
		t_fetch();
		tally_and_finish();
	end
endmodule
